// ---- core/eph_cfg.svh ----
// Constants of the e-paper host serial port, both ends
`ifndef EPH_CFG_SVH
`define EPH_CFG_SVH
// System clock and serial clock half period
`define EPH_CLK_PERIOD_NS 4
`define EPH_SCL_HALF_NS 250
`define EPH_SCL_HALF_CYC ((`EPH_SCL_HALF_NS + `EPH_CLK_PERIOD_NS - 1) / `EPH_CLK_PERIOD_NS)
// Word lengths per link width
`define EPH_BITS_4W 4'h8
`define EPH_BITS_3W 4'h9
`define EPH_BITS_3W_RD 4'ha
`define EPH_LAST_BIT 3'h7
// Controller register byte offsets
`define EPH_REG_CONFIG 8'h00
`define EPH_REG_CMD 8'h04
`define EPH_REG_RXDATA 8'h08
`define EPH_REG_STATUS 8'h0c
`define EPH_REG_IRQ_EN 8'h10
`define EPH_REG_IRQ_CLR 8'h14
`define EPH_REG_REFRESH 8'h18
// CONFIG fields
`define EPH_CFG_CLEAR 0
`define EPH_CFG_3W 1
// CMD fields
`define EPH_CMD_IS_DATA 8
`define EPH_CMD_READ 9
`define EPH_CMD_HOLD 10
`define EPH_CMD_CNT_LO 12
`define EPH_CMD_CNT_HI 15
// STATUS fields
`define EPH_ST_DONE 0
`define EPH_ST_RX 1
`define EPH_ST_FULL_DUE 2
`define EPH_ST_BUSY 8
`define EPH_ST_ACTIVE 9
`define EPH_EVENTS 3
// REFRESH fields and limit
`define EPH_REF_PARTIAL 0
`define EPH_REF_FULL 1
`define EPH_PARTIAL_LIMIT 3'h5
`endif

// ---- core/eph_pkg.sv ----
// Types shared by both ends of the e-paper serial port
package eph_pkg;
	typedef enum logic [1:0] {
		EPH_DEV_WRITE,
		EPH_DEV_RD_FLAG,
		EPH_DEV_READ
	} eph_dev_st_t;
	typedef enum logic [2:0] {
		EPH_HOST_IDLE,
		EPH_HOST_WAIT,
		EPH_HOST_LEAD,
		EPH_HOST_LOW,
		EPH_HOST_HIGH,
		EPH_HOST_RLOW,
		EPH_HOST_RHIGH,
		EPH_HOST_TAIL
	} eph_host_st_t;
endpackage

// ---- core/eph_link_if.sv ----
// Serial link between host controller and display port
`timescale 1ns/100ps
interface eph_link_if;
	logic sclk;
	logic cs_n;
	logic dc;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;
	logic busy;
	logic chip_clear_low;
	logic link_width_strap;
	// Shared data wire, pulled high when nobody drives
	assign sda = dev_sda_oe ? dev_sda_o : (host_sda_oe ? host_sda_o : 1'b1);
	modport dev(input sclk, input cs_n, input dc, input sda, input chip_clear_low, input link_width_strap,
		output dev_sda_o, output dev_sda_oe, output busy);
	modport host(output sclk, output cs_n, output dc, output host_sda_o, output host_sda_oe,
		output chip_clear_low, output link_width_strap, input sda, input busy);
endinterface

// ---- core/eph_dev.sv ----
// Display-side serial port: word receiver, read shifter and busy output
`timescale 1ns/100ps
`include "eph_cfg.svh"
module eph_dev (
	input wire logic i_clk,
	input wire logic i_reset,
	eph_link_if.dev link,
	input wire logic i_wave_active,
	input wire logic i_sensor_active,
	input wire logic i_read_cmd,
	input wire logic [7:0] i_rd_byte,
	output logic o_word_valid,
	output logic o_word_is_data,
	output logic [7:0] o_word,
	output logic o_rd_next,
	output logic o_three_wire
);
	typedef struct packed {
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_s3;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic dc_s1;
		logic dc_s2;
		logic sda_s1;
		logic sda_s2;
		logic strap_s1;
		logic strap_s2;
		logic clr_s1;
		logic clr_s2;
		eph_pkg::eph_dev_st_t st;
		logic [8:0] sh;
		logic [3:0] cnt;
		logic [7:0] rd_sh;
		logic oe;
		logic rd_next;
		logic word_valid;
		logic word_is_data;
		logic [7:0] word;
		logic busy;
	} eph_dev_state_t;

	eph_dev_state_t q;
	eph_dev_state_t d;
	logic three;
	logic active;
	logic rise;
	logic fall;
	logic cs_rise;
	logic [8:0] nsh;
	logic last;
	logic is_data;

	// Edge and mode decode, all from second synchroniser stages onward
	assign three = q.strap_s2;
	assign active = ~q.cs_s2;
	assign rise = q.sclk_s2 & ~q.sclk_s3;
	assign fall = ~q.sclk_s2 & q.sclk_s3;
	assign cs_rise = q.cs_s2 & ~q.cs_s3;
	assign nsh = {q.sh[7:0], q.sda_s2};
	assign last = q.cnt == (three ? `EPH_BITS_3W - 4'h1 : `EPH_BITS_4W - 4'h1);

	// 3-wire takes the leading flag, 4-wire the pin, which is ignored in 3-wire mode
	assign is_data = three ? nsh[8] : q.dc_s2;

	// Next state of the whole port
	always_comb begin
		d = q;
		d.sclk_s1 = link.sclk;
		d.sclk_s2 = q.sclk_s1;
		d.sclk_s3 = q.sclk_s2;
		d.cs_s1 = link.cs_n;
		d.cs_s2 = q.cs_s1;
		d.cs_s3 = q.cs_s2;
		d.dc_s1 = link.dc;
		d.dc_s2 = q.dc_s1;
		d.sda_s1 = link.sda;
		d.sda_s2 = q.sda_s1;
		d.strap_s1 = link.link_width_strap;
		d.strap_s2 = q.strap_s1;
		d.clr_s1 = link.chip_clear_low;
		d.clr_s2 = q.clr_s1;
		d.word_valid = 1'b0;
		d.rd_next = 1'b0;
		// Busy is a pure level of the two long-running activities
		d.busy = i_wave_active | i_sensor_active;
		if (cs_rise) begin
			// Partial word thrown away, read ends, data line released
			d.cnt = 4'h0;
			d.sh = 9'h000;
			d.st = eph_pkg::EPH_DEV_WRITE;
			d.oe = 1'b0;
		end else if (active) begin
			unique case (q.st)
				eph_pkg::EPH_DEV_WRITE: begin
					// Read command decoded by user logic one cycle after the word
					if (q.word_valid && !q.word_is_data && i_read_cmd) begin
						d.st = three ? eph_pkg::EPH_DEV_RD_FLAG : eph_pkg::EPH_DEV_READ;
						d.cnt = 4'h0;
					end else if (rise) begin
						d.sh = nsh;
						if (last) begin
							// Hand the complete byte on, tagged command or data
							d.word = nsh[7:0];
							d.word_is_data = is_data;
							d.word_valid = 1'b1;
							d.cnt = 4'h0;
						end else begin
							d.cnt = q.cnt + 4'h1;
						end
					end
				end
				eph_pkg::EPH_DEV_RD_FLAG: begin
					// Single rising edge carrying the flag of one
					if (rise) begin
						d.st = eph_pkg::EPH_DEV_READ;
						d.cnt = 4'h0;
					end
				end
				eph_pkg::EPH_DEV_READ: begin
					// Rising edges count host samples, falling edges move the line
					if (rise) begin
						d.cnt = (q.cnt[2:0] == `EPH_LAST_BIT) ? 4'h0 : q.cnt + 4'h1;
					end else if (fall) begin
						if (q.cnt == 4'h0) begin
							// New byte each eight bits, as many as the host clocks
							d.rd_sh = i_rd_byte;
							d.oe = 1'b1;
							d.rd_next = 1'b1;
						end else begin
							d.rd_sh = {q.rd_sh[6:0], 1'b0};
						end
					end
				end
			endcase
		end
		// Pin reset clears everything but the synchronisers themselves
		if (!q.clr_s2) begin
			d.st = eph_pkg::EPH_DEV_WRITE;
			d.sh = 9'h000;
			d.cnt = 4'h0;
			d.rd_sh = 8'h00;
			d.oe = 1'b0;
			d.rd_next = 1'b0;
			d.word_valid = 1'b0;
			d.word_is_data = 1'b0;
			d.word = 8'h00;
			d.busy = 1'b0;
		end
	end

	// State register; clock, select and clear synchronisers start high so no false rising edge at release
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			q <= '0;
			q.sclk_s1 <= 1'b1;
			q.sclk_s2 <= 1'b1;
			q.sclk_s3 <= 1'b1;
			q.cs_s1 <= 1'b1;
			q.cs_s2 <= 1'b1;
			q.cs_s3 <= 1'b1;
			q.clr_s1 <= 1'b1;
			q.clr_s2 <= 1'b1;
			q.st <= eph_pkg::EPH_DEV_WRITE;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign link.dev_sda_o = q.rd_sh[7];
	assign link.dev_sda_oe = q.oe;
	assign link.busy = q.busy;
	assign o_word_valid = q.word_valid;
	assign o_word_is_data = q.word_is_data;
	assign o_word = q.word;
	assign o_rd_next = q.rd_next;
	assign o_three_wire = q.strap_s2;
endmodule // eph_dev

// ---- core/eph_host.sv ----
// Host-side serial controller with register port and interrupt
`timescale 1ns/100ps
`include "eph_cfg.svh"
module eph_host #(
	parameter int HALF_CYC = `EPH_SCL_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset,
	eph_link_if.host link,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_irq
);
	typedef struct packed {
		eph_pkg::eph_host_st_t st;
		logic cs_n;
		logic sclk;
		logic dc;
		logic sda_o;
		logic sda_oe;
		logic [9:0] sh;
		logic [3:0] nbits;
		logic [3:0] bitc;
		logic [7:0] timer;
		logic [4:0] rd_left;
		logic rd;
		logic hold;
		logic busy_s1;
		logic busy_s2;
		logic sda_s1;
		logic sda_s2;
		logic [7:0] rxsh;
		logic [7:0] rx;
		logic [1:0] cfg;
		logic [2:0] irq_en;
		logic [2:0] status;
		logic [2:0] ref_cnt;
		logic [31:0] rdata;
	} eph_host_state_t;

	eph_host_state_t q;
	eph_host_state_t d;
	logic tick;
	logic three;
	logic [2:0] ev;
	logic [3:0] cnt_f;

	assign tick = q.timer == 8'(HALF_CYC - 1);
	assign three = q.cfg[`EPH_CFG_3W];
	assign cnt_f = i_wdata[`EPH_CMD_CNT_HI:`EPH_CMD_CNT_LO];

	// Engine, registers and event collection
	always_comb begin
		d = q;
		ev = 3'h0;
		d.busy_s1 = link.busy;
		d.busy_s2 = q.busy_s1;
		d.sda_s1 = link.sda;
		d.sda_s2 = q.sda_s1;
		d.timer = (q.st == eph_pkg::EPH_HOST_IDLE || tick) ? 8'h00 : q.timer + 8'h01;
		unique case (q.st)
			eph_pkg::EPH_HOST_IDLE: begin
				// New order only when idle; writes while active are dropped
				if (i_wr && i_addr == `EPH_REG_CMD) begin
					d.rd = i_wdata[`EPH_CMD_READ];
					d.hold = i_wdata[`EPH_CMD_HOLD];
					d.rd_left = (cnt_f == 4'h0) ? 5'h01 : {1'b0, cnt_f};
					d.bitc = 4'h0;
					if (three && i_wdata[`EPH_CMD_READ]) begin
						d.sh = {1'b0, i_wdata[7:0], 1'b1};
						d.nbits = `EPH_BITS_3W_RD;
					end else if (three) begin
						d.sh = {i_wdata[`EPH_CMD_IS_DATA], i_wdata[7:0], 1'b0};
						d.nbits = `EPH_BITS_3W;
					end else begin
						d.sh = {i_wdata[7:0], 2'b00};
						d.nbits = `EPH_BITS_4W;
					end
					d.dc = i_wdata[`EPH_CMD_IS_DATA] & ~i_wdata[`EPH_CMD_READ];
					d.st = eph_pkg::EPH_HOST_WAIT;
				end
			end
			eph_pkg::EPH_HOST_WAIT: begin
				// Nothing starts while the display reports busy
				if (!q.busy_s2) begin
					d.cs_n = 1'b0;
					d.sda_o = q.sh[9];
					d.sda_oe = 1'b1;
					d.timer = 8'h00;
					d.st = eph_pkg::EPH_HOST_LEAD;
				end
			end
			eph_pkg::EPH_HOST_LEAD, eph_pkg::EPH_HOST_LOW: begin
				if (tick) begin
					d.sclk = 1'b1;
					d.st = eph_pkg::EPH_HOST_HIGH;
				end
			end
			eph_pkg::EPH_HOST_HIGH: begin
				if (tick) begin
					d.sclk = 1'b0;
					d.sh = {q.sh[8:0], 1'b0};
					d.bitc = q.bitc + 4'h1;
					if (q.bitc + 4'h1 == q.nbits) begin
						d.bitc = 4'h0;
						if (q.rd) begin
							// Clock falls in this same cycle: raise command/data and let go of the line
							d.dc = 1'b1;
							d.sda_oe = 1'b0;
							d.st = eph_pkg::EPH_HOST_RLOW;
						end else begin
							d.st = eph_pkg::EPH_HOST_TAIL;
						end
					end else begin
						d.sda_o = q.sh[8];
						d.st = eph_pkg::EPH_HOST_LOW;
					end
				end
			end
			eph_pkg::EPH_HOST_RLOW: begin
				// Sample just as the clock rises; device moved it a half period ago
				if (tick) begin
					d.sclk = 1'b1;
					d.rxsh = {q.rxsh[6:0], q.sda_s2};
					d.st = eph_pkg::EPH_HOST_RHIGH;
				end
			end
			eph_pkg::EPH_HOST_RHIGH: begin
				if (tick) begin
					d.sclk = 1'b0;
					d.bitc = q.bitc + 4'h1;
					d.st = eph_pkg::EPH_HOST_RLOW;
					if (q.bitc[2:0] == `EPH_LAST_BIT) begin
						d.bitc = 4'h0;
						d.rx = q.rxsh;
						ev[`EPH_ST_RX] = 1'b1;
						d.rd_left = q.rd_left - 5'h01;
						if (q.rd_left == 5'h01) begin
							d.st = eph_pkg::EPH_HOST_TAIL;
						end
					end
				end
			end
			eph_pkg::EPH_HOST_TAIL: begin
				// Select rises after the last byte unless the order keeps it low
				if (tick) begin
					// A read always ends with select high; hold only applies to writes
					d.cs_n = ~(q.hold & ~q.rd);
					d.sda_oe = 1'b0;
					ev[`EPH_ST_DONE] = 1'b1;
					d.st = eph_pkg::EPH_HOST_IDLE;
				end
			end
		endcase
		// Partial refresh bookkeeping; a full refresh restarts the count
		if (i_wr && i_addr == `EPH_REG_REFRESH) begin
			if (i_wdata[`EPH_REF_FULL]) begin
				d.ref_cnt = 3'h0;
			end else if (i_wdata[`EPH_REF_PARTIAL] && q.ref_cnt != `EPH_PARTIAL_LIMIT) begin
				d.ref_cnt = q.ref_cnt + 3'h1;
				ev[`EPH_ST_FULL_DUE] = (q.ref_cnt + 3'h1 == `EPH_PARTIAL_LIMIT);
			end
		end
		if (i_wr && i_addr == `EPH_REG_CONFIG) begin
			d.cfg = i_wdata[1:0];
		end
		if (i_wr && i_addr == `EPH_REG_IRQ_EN) begin
			d.irq_en = i_wdata[2:0];
		end
		// Clear first, then events, so a same-cycle event survives
		if (i_wr && i_addr == `EPH_REG_IRQ_CLR) begin
			d.status = q.status & ~i_wdata[2:0];
		end
		d.status = d.status | ev;
		d.rdata = 32'h0000_0000;
		if (i_rd) begin
			unique case (i_addr)
				`EPH_REG_CONFIG: d.rdata = {30'h0, q.cfg};
				`EPH_REG_RXDATA: d.rdata = {24'h0, q.rx};
				`EPH_REG_STATUS: d.rdata = {22'h0, q.st != eph_pkg::EPH_HOST_IDLE, q.busy_s2, 5'h0, q.status};
				`EPH_REG_IRQ_EN: d.rdata = {29'h0, q.irq_en};
				default: d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			q <= '0;
			q.cs_n <= 1'b1;
			q.st <= eph_pkg::EPH_HOST_IDLE;
		end else begin
			q <= d;
		end
	end

	// Link pins; command/data is held low in 3-wire mode
	assign link.sclk = q.sclk;
	assign link.cs_n = q.cs_n;
	assign link.dc = three ? 1'b0 : q.dc;
	assign link.host_sda_o = q.sda_o;
	assign link.host_sda_oe = q.sda_oe;
	assign link.chip_clear_low = ~q.cfg[`EPH_CFG_CLEAR];
	assign link.link_width_strap = three;
	assign o_rdata = q.rdata;
	assign o_irq = |(q.status & q.irq_en);
endmodule // eph_host

// ---- tb/eph_link_monitor.sv ----
// Protocol checker on the serial link between both ends
`timescale 1ns/100ps
module eph_link_monitor #(
	parameter int HALF_CYC = 8
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic dc,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic busy,
	input wire logic chip_clear_low,
	input wire logic link_width_strap
);
	logic last_q;
	int run_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Cycles since the serial clock last moved, to time the high half
	always_ff @(posedge i_clk) begin
		last_q <= sclk;
		run_q <= (sclk != last_q) ? 0 : run_q + 1;
	end
	chk_clk_idle: assert property (cs_n |-> !sclk) else $error("clock moves while deselected");
	chk_drive_sel: assert property (cs_n [*8] |-> !dev_sda_oe) else $error("port drives while deselected");
	chk_no_clash: assert property (dev_sda_oe && !cs_n |-> !host_sda_oe) else $error("both ends drive data");
	chk_busy_hold: assert property (busy [*6] |-> !$fell(cs_n)) else $error("frame started while busy");
	chk_dc_tied: assert property (link_width_strap && !cs_n |-> !dc) else $error("command pin not low");
	chk_high_stable: assert property (!cs_n && sclk && $past(sclk) |-> $stable(sda) && $stable(dc))
		else $error("data or command pin moved while clock high");
	chk_half_len: assert property ($fell(sclk) |-> run_q == HALF_CYC - 1) else $error("clock high half length");
	chk_clear_quiet: assert property (!chip_clear_low [*6] |-> !dev_sda_oe && !busy) else $error("active in reset");
endmodule // eph_link_monitor

// ---- tb/testbench.sv ----
// Testbench joining host controller and display port
`timescale 1ns/100ps
`include "eph_cfg.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("Error %0t: got %h want %h", $time, a, e); end end
module testbench;
	logic i_clk, i_reset, i_wr, i_rd, i_wave_active, i_sensor_active, i_read_cmd;
	logic o_irq, o_word_valid, o_word_is_data, o_rd_next, o_three_wire;
	logic [7:0] i_addr, i_rd_byte, o_word;
	logic [31:0] i_wdata, o_rdata, v;
	int n_mismatch, tests_run, k, m;
	logic [8:0] wq[$];
	logic [7:0] rq[$], xq[$];
	logic [7:0] holes[5] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h1c};
	eph_link_if link();
	eph_host #(.HALF_CYC(8)) i_eph_host(.i_clk(i_clk), .i_reset(i_reset), .link(link), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
	eph_dev i_eph_dev(.i_clk(i_clk), .i_reset(i_reset), .link(link), .i_wave_active(i_wave_active),
		.i_sensor_active(i_sensor_active), .i_read_cmd(i_read_cmd), .i_rd_byte(i_rd_byte),
		.o_word_valid(o_word_valid), .o_word_is_data(o_word_is_data), .o_word(o_word), .o_rd_next(o_rd_next),
		.o_three_wire(o_three_wire));
	eph_link_monitor #(.HALF_CYC(8)) i_eph_link_monitor(.i_clk(i_clk), .i_reset(i_reset), .sclk(link.sclk),
		.cs_n(link.cs_n), .dc(link.dc), .sda(link.sda), .host_sda_oe(link.host_sda_oe),
		.dev_sda_oe(link.dev_sda_oe), .busy(link.busy), .chip_clear_low(link.chip_clear_low),
		.link_width_strap(link.link_width_strap));
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	// Received words against the model queue; read bytes handed out in order
	always @(posedge i_clk) begin
		if (o_word_valid) begin
			`CHK(wq.size() > 0, 1'b1)
			if (wq.size()) begin
				`CHK(o_word, wq[0][7:0])
				`CHK(o_word_is_data, wq[0][8])
				void'(wq.pop_front());
			end
		end
		if (o_rd_next && rq.size())
			void'(rq.pop_front());
		i_rd_byte <= rq.size() ? rq[0] : 8'h00;
	end
	// Gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		@(posedge i_clk);
	endtask
	task automatic waitst(input int b);
		v = 32'h0;
		for (int n = 0; n < 3000 && v[b] !== 1'b1; n++)
			rd(`EPH_REG_STATUS, v);
		`CHK(v[b], 1'b1)
		`CHK(o_irq, 1'b1)
	endtask
	task automatic go(input logic [8:0] w);
		wq.push_back(w);
		wr(`EPH_REG_CMD, {23'h0, w});
	endtask
	task automatic fin();
		waitst(0);
		wr(`EPH_REG_IRQ_CLR, 32'h1);
	endtask
	// Two-byte register read; command word goes to the receiver first
	task automatic rdx(input logic [7:0] r);
		for (int j = 0; j < 2; j++)
			rq.push_back(8'($urandom));
		xq = rq;
		i_read_cmd <= 1'b1;
		// Command byte with the read flag and a count of two bytes
		wq.push_back({1'b0, r});
		wr(`EPH_REG_CMD, {16'h0, 8'h22, r});
		for (int j = 0; j < 2; j++) begin
			waitst(1);
			rd(`EPH_REG_RXDATA, v);
			`CHK(v[7:0], xq[j])
			wr(`EPH_REG_IRQ_CLR, 32'h2);
		end
		fin();
		i_read_cmd <= 1'b0;
	endtask
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		n_mismatch = 0;
		tests_run = 0;
		i_reset = 1'b1;
		{i_wr, i_rd, i_wave_active, i_sensor_active, i_read_cmd} = 5'h00;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		void'($urandom(32'h9fa9));
		repeat (8) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		wr(8'h1c, 32'hffff_ffff);
		// Reset values, status included, and an unmapped hole written all ones
		foreach (holes[i]) begin
			rd(holes[i], v);
			`CHK(v, 32'h0)
		end
		wr(`EPH_REG_IRQ_EN, 32'h7);
		// Each busy source holds a pending frame back
		for (k = 0; k < 2; k++) begin
			{i_sensor_active, i_wave_active} <= 2'(k + 1);
			repeat (4) @(posedge i_clk);
			go({1'b1, 8'($urandom)});
			repeat (40) @(posedge i_clk);
			`CHK(link.cs_n, 1'b1)
			rd(`EPH_REG_STATUS, v);
			`CHK(v[9:8], 2'b11)
			{i_sensor_active, i_wave_active} <= 2'b00;
			fin();
		end
		// Both link widths: commands, data, then a read
		for (m = 0; m < 2; m++) begin
			wr(`EPH_REG_CONFIG, 32'(m) << 1);
			repeat (4) @(posedge i_clk);
			`CHK(o_three_wire, 1'(m))
			for (k = 0; k < 6; k++) begin
				go({1'(k), 8'($urandom)});
				fin();
			end
			// Held select joins two data words into one frame
			v = {21'h0, 3'h5, 8'($urandom)};
			wq.push_back(v[8:0]);
			wr(`EPH_REG_CMD, v);
			fin();
			`CHK(link.cs_n, 1'b0)
			go({1'b1, 8'($urandom)});
			fin();
			`CHK(link.cs_n, 1'b1)
			rdx(8'($urandom));
		end
		for (k = 1; k < 6; k++) begin
			wr(`EPH_REG_REFRESH, 32'h1);
			rd(`EPH_REG_STATUS, v);
			`CHK(v[2], 1'(k == 5))
		end
		wr(`EPH_REG_IRQ_EN, 32'h0);
		`CHK(o_irq, 1'b0)
		wr(`EPH_REG_IRQ_EN, 32'h4);
		`CHK(o_irq, 1'b1)
		wr(`EPH_REG_REFRESH, 32'h2);
		wr(`EPH_REG_IRQ_CLR, 32'h4);
		`CHK(o_irq, 1'b0)
		// Held chip clear silences busy until released
		wr(`EPH_REG_CONFIG, 32'h1);
		i_wave_active <= 1'b1;
		repeat (8) @(posedge i_clk);
		`CHK(link.chip_clear_low, 1'b0)
		`CHK(link.busy, 1'b0)
		wr(`EPH_REG_CONFIG, 32'h0);
		repeat (8) @(posedge i_clk);
		`CHK(link.busy, 1'b1)
		`CHK(wq.size(), 0)
		stop_test();
	end
endmodule // testbench
